// ===== src/ibc_pkg.sv
package ibc_pkg;

    // ****************************************
    // Register map (byte offsets = index * 4)
    // ****************************************
    localparam logic [2:0] IDX_DIV_LO   = 3'h0;
    localparam logic [2:0] IDX_DIV_HI   = 3'h1;
    localparam logic [2:0] IDX_CONTROL  = 3'h2;
    localparam logic [2:0] IDX_DATA     = 3'h3;
    localparam logic [2:0] IDX_CMD_STAT = 3'h4;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTL_ENABLE   = 7;
    localparam int CTL_IRQ      = 6;
    localparam int CMD_BEGIN    = 7;
    localparam int CMD_END      = 6;
    localparam int CMD_READ     = 5;
    localparam int CMD_WRITE    = 4;
    localparam int CMD_NACK     = 3;
    localparam int CMD_IRQ_CLR  = 0;
    localparam int ST_RESPONSE  = 7;
    localparam int ST_BUSY      = 6;
    localparam int ST_ARB_LOST  = 5;
    localparam int ST_UNDERWAY  = 1;
    localparam int ST_IRQ       = 0;

    // ****************************************
    // Reset values and widths
    // ****************************************
    localparam logic [15:0] DIV_RESET     = 16'hFFFF;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [1:0]  CTL_RW_MASK   = 2'h3;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    localparam logic [2:0]  LAST_PHASE    = 3'h4;
    localparam logic [2:0]  LAST_PHASE_P  = 3'h3;

    // Bit-level operations
    typedef enum logic [2:0] {
        IBC_OP_NONE  = 3'b000,
        IBC_OP_START = 3'b001,
        IBC_OP_STOP  = 3'b010,
        IBC_OP_WRITE = 3'b011,
        IBC_OP_READ  = 3'b100
    } ibc_op_e;

    // Byte sequencer states
    typedef enum logic [2:0] {
        IBC_IDLE   = 3'b000,
        IBC_START  = 3'b001,
        IBC_DATA   = 3'b010,
        IBC_ACK    = 3'b011,
        IBC_STOP   = 3'b100
    } ibc_state_e;

endpackage

// ===== src/ibc_master.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module ibc_master
    import ibc_pkg::*;
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt request
    output logic             irq,
    // I2C clock line (open drain)
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    // I2C data line (open drain)
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);

    // ****************************************
    // Registers
    // ****************************************
    logic [15:0]  div_reg;
    logic [7:0]   control_reg;
    logic [7:0]   outgoing_reg;
    logic [7:0]   incoming_reg;
    logic [7:0]   cmd_reg;
    logic         response_reg;
    logic         busy_reg;
    logic         arb_lost_reg;
    logic         irq_flag_reg;
    logic         underway_reg;
    logic         done_pulse;
    logic         arb_pulse;

    // Bus decode
    logic         wr_en;
    logic         rd_en;
    logic [2:0]   reg_idx;
    logic         addr_ok;

    // Word index: printed offsets are not word aligned
    function automatic logic [2:0] ibc_index(input logic [11:0] a);
        return a[4:2];
    endfunction

    assign reg_idx = ibc_index(paddr);
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:5] == 7'h00) &&
                     (reg_idx <= IDX_CMD_STAT);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg      <= DIV_RESET;
            control_reg  <= BYTE_ZERO;
            outgoing_reg <= BYTE_ZERO;
        end else if (wr_en) begin
            case (reg_idx)
                IDX_DIV_LO:  div_reg[7:0]  <= pwdata[7:0];
                IDX_DIV_HI:  div_reg[15:8] <= pwdata[7:0];
                IDX_CONTROL: control_reg   <= {pwdata[7:6] & CTL_RW_MASK, 6'h00};
                IDX_DATA:    outgoing_reg  <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Command: accepted only while enabled; action bits self-clear
    logic seq_done;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= BYTE_ZERO;
        end else if (wr_en && reg_idx == IDX_CMD_STAT && control_reg[CTL_ENABLE]) begin
            cmd_reg <= {pwdata[7:3], 3'h0};
        end else if (seq_done || arb_pulse) begin
            cmd_reg[7:4] <= 4'h0;
        end
    end

    // Interrupt flag: set wins over clear; rises as underway falls, never after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_reg <= 1'b0;
        end else if (seq_done || arb_pulse) begin
            irq_flag_reg <= 1'b1;
        end else if (wr_en && reg_idx == IDX_CMD_STAT && pwdata[CMD_IRQ_CLR]) begin
            irq_flag_reg <= 1'b0;
        end
    end

    assign irq = irq_flag_reg && control_reg[CTL_IRQ];

    // Read mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            prdata <= 32'h0000_0000;
            case (reg_idx)
                IDX_DIV_LO:   prdata[7:0] <= div_reg[7:0];
                IDX_DIV_HI:   prdata[7:0] <= div_reg[15:8];
                IDX_CONTROL:  prdata[7:0] <= control_reg;
                IDX_DATA:     prdata[7:0] <= incoming_reg;
                IDX_CMD_STAT: prdata[7:0] <= {response_reg, busy_reg, arb_lost_reg,
                                              3'h0, underway_reg, irq_flag_reg};
                default:      prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Line synchronisers and bus watch
    // ****************************************
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       sda_prev;
    logic       scl_line;
    logic       sda_line;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            sda_prev <= sda_sync[1];
        end
    end
    assign scl_line = scl_sync[1];
    assign sda_line = sda_sync[1];

    logic bus_start;
    logic bus_stop;
    assign bus_start = scl_line && sda_prev && !sda_line;
    assign bus_stop  = scl_line && !sda_prev && sda_line;

    // Busy follows start and stop seen on the wires
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg <= 1'b0;
        end else if (bus_start) begin
            busy_reg <= 1'b1;
        end else if (bus_stop) begin
            busy_reg <= 1'b0;
        end
    end

    // ****************************************
    // Phase clock enable (five per SCL bit)
    // ****************************************
    logic [15:0] div_cnt;
    logic        tick;
    logic        stretch;
    assign stretch = !scl_oe && !scl_line;  // Released but read low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0000;
        end else if (!control_reg[CTL_ENABLE] && !underway_reg) begin
            div_cnt <= div_reg;
        end else if (div_cnt == 16'h0000) begin
            div_cnt <= div_reg;
        end else if (!stretch) begin
            div_cnt <= div_cnt - 16'h0001;
        end
    end
    assign tick = (div_cnt == 16'h0000) && !stretch;

    // ****************************************
    // Bit engine
    // ****************************************
    ibc_op_e     op;
    logic [2:0]  phase;
    logic        bit_tx;
    logic        bit_rx;
    logic        bit_done;
    logic        sda_drive;
    logic        scl_drive;
    logic        bit_active;
    logic        stop_wanted;

    // Each op runs idle plus five phases (0 to 4); stop stops after four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase      <= 3'h0;
            scl_drive  <= 1'b1;
            sda_drive  <= 1'b1;
            bit_rx     <= 1'b0;
            arb_pulse  <= 1'b0;
            bit_active <= 1'b0;
        end else begin
            arb_pulse <= 1'b0;
            if (bit_active && scl_drive && sda_drive && !sda_line &&
                (op == IBC_OP_WRITE) && phase >= 3'h2) begin
                arb_pulse  <= 1'b1;
                bit_active <= 1'b0;
                sda_drive  <= 1'b1;
                scl_drive  <= 1'b1;
                phase      <= 3'h0;
            end else if (bus_stop && underway_reg && op != IBC_OP_STOP) begin
                arb_pulse  <= 1'b1;
                bit_active <= 1'b0;
                sda_drive  <= 1'b1;
                scl_drive  <= 1'b1;
                phase      <= 3'h0;
            end else if (op != IBC_OP_NONE && !bit_active && !arb_pulse) begin  // No phantom bit
                bit_active <= 1'b1;
                phase      <= 3'h0;
            end else if (bit_active && tick) begin
                phase <= phase + 3'h1;
                case (op)
                    IBC_OP_START: begin
                        case (phase)
                            3'h0: sda_drive <= 1'b1;
                            3'h1: scl_drive <= 1'b1;
                            3'h2: sda_drive <= 1'b0;
                            3'h3: scl_drive <= 1'b1;
                            default: scl_drive <= 1'b0;
                        endcase
                    end
                    IBC_OP_STOP: begin
                        case (phase)
                            3'h0: begin
                                scl_drive <= 1'b0;
                                sda_drive <= 1'b0;
                            end
                            3'h1: scl_drive <= 1'b1;
                            3'h2: sda_drive <= 1'b0;
                            default: sda_drive <= 1'b1;
                        endcase
                    end
                    default: begin
                        case (phase)
                            3'h0: scl_drive <= 1'b0;
                            3'h1: sda_drive <= bit_tx;
                            3'h2: scl_drive <= 1'b1;
                            3'h3: bit_rx    <= sda_line;
                            default: scl_drive <= 1'b0;
                        endcase
                    end
                endcase
                if (phase == ((op == IBC_OP_STOP) ? LAST_PHASE_P : LAST_PHASE)) begin
                    bit_active <= 1'b0;
                end
            end
        end
    end
    assign bit_done = bit_active && tick &&
                      (phase == ((op == IBC_OP_STOP) ? LAST_PHASE_P : LAST_PHASE));

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = !scl_drive;
    assign sda_oe  = !sda_drive;

    // ****************************************
    // Byte sequencer
    // ****************************************
    ibc_state_e  state;
    logic [7:0]  shift_reg;
    logic [3:0]  bit_cnt;
    logic        was_read;

    assign underway_reg = (state != IBC_IDLE);
    assign stop_wanted  = cmd_reg[CMD_END];

    always_comb begin
        case (state)
            IBC_START: op = IBC_OP_START;
            IBC_DATA:  op = was_read ? IBC_OP_READ : IBC_OP_WRITE;
            IBC_ACK:   op = was_read ? IBC_OP_WRITE : IBC_OP_READ;
            IBC_STOP:  op = IBC_OP_STOP;
            default:   op = IBC_OP_NONE;
        endcase
    end

    // Ack slot: receiver drives own choice, transmitter releases
    assign bit_tx = (state == IBC_ACK) ? (was_read ? cmd_reg[CMD_NACK] : 1'b1)
                                       : (was_read ? 1'b1 : shift_reg[7]);

    assign seq_done = bit_done && ((state == IBC_STOP) ||
                                   (state == IBC_ACK && !stop_wanted));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= seq_done;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state        <= IBC_IDLE;
            shift_reg    <= BYTE_ZERO;
            bit_cnt      <= 4'h0;
            was_read     <= 1'b0;
            incoming_reg <= BYTE_ZERO;
            response_reg <= 1'b0;
        end else if (arb_pulse) begin
            state <= IBC_IDLE;
        end else begin
            case (state)
                IBC_IDLE: begin
                    bit_cnt  <= 4'h0;
                    was_read <= cmd_reg[CMD_READ];
                    shift_reg <= outgoing_reg;
                    if ((cmd_reg[CMD_READ] || cmd_reg[CMD_WRITE]) && !done_pulse) begin
                        state <= cmd_reg[CMD_BEGIN] ? IBC_START : IBC_DATA;
                    end else if (cmd_reg[CMD_END] && !done_pulse) begin
                        state <= IBC_STOP;
                    end
                end
                IBC_START: if (bit_done) state <= IBC_DATA;
                IBC_DATA: if (bit_done) begin
                    shift_reg <= {shift_reg[6:0], bit_rx};
                    bit_cnt   <= bit_cnt + 4'h1;
                    if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
                        state <= IBC_ACK;
                    end
                end
                IBC_ACK: if (bit_done) begin
                    if (was_read) begin
                        incoming_reg <= shift_reg;
                    end else begin
                        response_reg <= bit_rx;
                    end
                    state <= stop_wanted ? IBC_STOP : IBC_IDLE;
                end
                IBC_STOP: if (bit_done) state <= IBC_IDLE;
                default: state <= IBC_IDLE;
            endcase
        end
    end

    // Arbitration lost: sticky until the next start command is taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arb_lost_reg <= 1'b0;
        end else if (arb_pulse) begin
            arb_lost_reg <= 1'b1;
        end else if (state == IBC_IDLE && cmd_reg[CMD_BEGIN]) begin
            arb_lost_reg <= 1'b0;
        end
    end

endmodule

// ===== tb/ibc_master_chk.sv
`timescale 1ns/1ps
module ibc_master_chk
    import ibc_pkg::*;
(
    // APB side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    // Two-wire side
    input wire logic        scl_in,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe
);
    logic        en_q;
    logic        ien_q;
    logic [15:0] div_q;
    logic        wr;
    logic        rd_set;
    logic        cmd;
    logic        xfer;

    // Bus decode; link bounds only hold for a fast divider
    assign wr     = psel && penable && pwrite && pready;
    assign rd_set = psel && !penable && !pwrite;
    assign cmd    = wr && paddr[4:2] == IDX_CMD_STAT && en_q && div_q < 16'h0010;
    assign xfer   = pwdata[CMD_READ] || pwdata[CMD_WRITE];

    // Shadow of control and divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q  <= 1'b0;
            ien_q <= 1'b0;
            div_q <= DIV_RESET;
        end else if (wr && paddr[4:2] == IDX_CONTROL) begin
            en_q  <= pwdata[CTL_ENABLE];
            ien_q <= pwdata[CTL_IRQ];
        end else if (wr && paddr[4:2] == IDX_DIV_LO) begin
            div_q[7:0] <= pwdata[7:0];
        end else if (wr && paddr[4:2] == IDX_DIV_HI) begin
            div_q[15:8] <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_upper_zero: assert property (rd_set |=> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_ctl_reserved: assert property (rd_set && paddr[4:2] == IDX_CONTROL |=> prdata[5:0] == 6'h00)
        else $error("control reserved bits set");
    a_stat_reserved: assert property (rd_set && paddr[4:2] == IDX_CMD_STAT |=> prdata[4:2] == 3'h0)
        else $error("status reserved bits set");
    a_irq_gated: assert property (irq |-> ien_q)
        else $error("irq while disabled");
    a_irq_flag: assert property (rd_set && paddr[4:2] == IDX_CMD_STAT && ien_q |=> prdata[ST_IRQ] == $past(irq))
        else $error("irq differs from flag");
    a_bad_addr: assert property (psel && penable |-> pslverr == (paddr[4:2] > IDX_CMD_STAT || paddr[1:0] != 2'h0 || paddr[11:5] != 7'h00))
        else $error("error response wrong");
    a_off_quiet: assert property (wr && paddr[4:2] == IDX_CMD_STAT && !en_q && !scl_oe && !sda_oe |=> (!scl_oe && !sda_oe)[*8])
        else $error("command acted while disabled");
    a_begin_seen: assert property (cmd && pwdata[CMD_BEGIN] && xfer |-> ##[1:300] ($fell(sda_in) && scl_in))
        else $error("no start on bus");
    a_end_seen: assert property (cmd && pwdata[CMD_END] && xfer |-> ##[1:1000] ($rose(sda_in) && scl_in))
        else $error("no stop on bus");
    a_scl_high: assert property ($fell(scl_oe) |-> !scl_oe[*2])
        else $error("clock high too short");

    c_cmd: cover property (cmd && xfer);
    c_irq: cover property (irq);
    c_stop: cover property ($rose(sda_in) && scl_in);
endmodule

bind ibc_master ibc_master_chk u_ibc_master_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
);

// ===== tb/ibc_slave_model.sv
`timescale 1ns/1ps
module ibc_slave_model #(
    parameter logic [6:0] ADDR    = 7'h2A,
    parameter logic [7:0] RD_BYTE = 8'hC6
) (
    // Wire levels
    input  wire logic       scl,
    input  wire logic       sda,
    // Pull-down and observations
    output logic            sda_pull,
    output logic [7:0]      got_byte,
    output logic            m_ack
);
    logic [3:0] cnt     = 4'hF;
    logic [7:0] shreg   = 8'h00;
    logic [7:0] txs     = 8'h00;
    logic       first   = 1'b0;
    logic       match   = 1'b0;
    logic       reading = 1'b0;

    initial begin
        sda_pull = 1'b0;
        got_byte = 8'h00;
        m_ack    = 1'b1;
    end

    // Start: the clock fall that follows is not a bit
    always @(negedge sda) begin
        if (scl) begin
            cnt      = 4'hF;
            first    = 1'b1;
            match    = 1'b0;
            sda_pull = 1'b0;
        end
    end

    // Stop: release and forget the address
    always @(posedge sda) begin
        if (scl) begin
            match    = 1'b0;
            sda_pull = 1'b0;
        end
    end

    // Sample while SCL is high
    always @(posedge scl) begin
        if (cnt < 4'h8)
            shreg = {shreg[6:0], sda};
        else if (cnt == 4'h8 && !first && reading)
            m_ack = sda;
        else if (cnt == 4'h8 && !first)
            got_byte = shreg;
    end

    // Change SDA only while SCL is low
    always @(negedge scl) begin
        if (cnt == 4'hF) begin
            cnt = 4'h0;
        end else if (cnt == 4'h8) begin
            cnt = 4'h0;
            if (first)
                reading = shreg[0];
            if (!first && reading && m_ack)
                match = 1'b0;
            first    = 1'b0;
            txs      = RD_BYTE;
            sda_pull = match && reading && !txs[7];
        end else begin
            cnt = cnt + 4'h1;
            txs = {txs[6:0], 1'b0};
            if (cnt == 4'h8 && first)
                match = shreg[7:1] == ADDR;
            if (cnt == 4'h8)
                sda_pull = match && (first || !reading);
            else
                sda_pull = match && reading && !first && !txs[7];
        end
    end
endmodule

// ===== tb/ibc_master_tb_top.sv
`timescale 1ns/1ps
module ibc_master_tb_top
    import ibc_pkg::*;
;
    localparam logic [6:0] SLV_ADDR = 7'h2A;
    localparam logic [7:0] SLV_BYTE = 8'hC6;
    localparam int         LIMIT    = 20000;

    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h00000000;
    logic        tb_pull  = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        scl_out;
    logic        scl_oe;
    logic        sda_out;
    logic        sda_oe;
    logic        slv_pull;
    logic [7:0]  slv_byte;
    logic        slv_ack;
    wire         scl_w;
    wire         sda_w;
    logic [7:0]  rdv;
    logic        rerr;
    int          errors   = 0;
    int          n_tests  = 0;
    int          cycles   = 0;

    // Wired-AND lines with pull-ups
    assign scl_w = scl_oe ? scl_out : 1'b1;
    assign sda_w = (sda_oe ? sda_out : 1'b1) & !slv_pull & !tb_pull;

    always #50 pclk = ~pclk;

    ibc_master u_ibc_master (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe)
    );
    ibc_slave_model #(.ADDR(SLV_ADDR), .RD_BYTE(SLV_BYTE)) u_ibc_slave_model (
        .scl(scl_w), .sda(sda_w), .sda_pull(slv_pull), .got_byte(slv_byte), .m_ack(slv_ack)
    );

    task automatic results();
        $display("errors %0d checks %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            results();
        end
    end

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer: setup, then access held until pready
    task automatic apb(input logic wr, input logic [2:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {7'h00, idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata[7:0];
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Poll status; bounded so a stuck flag cannot hang
    task automatic wait_st(input logic [7:0] mask, input logic [7:0] val);
        int n;
        n = 0;
        apb(1'b0, IDX_CMD_STAT, 8'h00);
        while ((rdv & mask) !== val && n < 400) begin
            apb(1'b0, IDX_CMD_STAT, 8'h00);
            n++;
        end
        check("status wait", rdv & mask, val);
    endtask

    task automatic t_regs();
        apb(1'b0, IDX_DIV_LO, 8'h00);
        check("div low reset", rdv, 8'hFF);
        apb(1'b0, IDX_DIV_HI, 8'h00);
        check("div high reset", rdv, 8'hFF);
        apb(1'b0, IDX_CMD_STAT, 8'h00);
        check("status reset", rdv, 8'h00);
        apb(1'b1, IDX_DIV_LO, 8'h01);
        apb(1'b1, IDX_DIV_HI, 8'h00);
        apb(1'b0, IDX_DIV_LO, 8'h00);
        check("div low", rdv, 8'h01);
        apb(1'b1, IDX_CONTROL, 8'h3F);
        apb(1'b0, IDX_CONTROL, 8'h00);
        check("control spare", rdv, 8'h00);
        apb(1'b1, 3'h6, 8'h55);
        check("unmapped err", {7'h00, rerr}, 8'h01);
    endtask

    // Commands are ignored while the core is off
    task automatic t_disabled();
        apb(1'b1, IDX_CONTROL, 8'h40);
        apb(1'b1, IDX_DATA, {SLV_ADDR, 1'b0});
        apb(1'b1, IDX_CMD_STAT, 8'h90);
        repeat (60) @(posedge pclk);
        apb(1'b0, IDX_CMD_STAT, 8'h00);
        check("ignored cmd", rdv, 8'h00);
        apb(1'b1, IDX_CONTROL, 8'hC0);
    endtask

    task automatic t_write();
        apb(1'b1, IDX_CMD_STAT, 8'h90);
        apb(1'b0, IDX_CMD_STAT, 8'h00);
        check("underway", rdv & 8'h02, 8'h02);
        wait_st(8'h02, 8'h00);
        check("addr acked", rdv, 8'h41);
        check("irq on", {7'h00, irq}, 8'h01);
        apb(1'b1, IDX_CMD_STAT, 8'h01);
        apb(1'b0, IDX_CMD_STAT, 8'h00);
        check("flag clear", rdv, 8'h40);
        check("irq off", {7'h00, irq}, 8'h00);
        apb(1'b1, IDX_DATA, 8'h5A);
        apb(1'b1, IDX_CMD_STAT, 8'h11);
        wait_st(8'h02, 8'h00);
        check("data byte", slv_byte, 8'h5A);
    endtask

    // Repeated start, read with ack, read with nack and stop
    task automatic t_read();
        apb(1'b1, IDX_DATA, {SLV_ADDR, 1'b1});
        apb(1'b1, IDX_CMD_STAT, 8'h91);
        wait_st(8'h02, 8'h00);
        check("read addr", rdv, 8'h41);
        apb(1'b1, IDX_CMD_STAT, 8'h21);
        wait_st(8'h02, 8'h00);
        apb(1'b0, IDX_DATA, 8'h00);
        check("read byte", rdv, SLV_BYTE);
        check("master ack", {7'h00, slv_ack}, 8'h00);
        apb(1'b1, IDX_CMD_STAT, 8'h69);
        wait_st(8'h42, 8'h00);
        check("master nack", {7'h00, slv_ack}, 8'h01);
        apb(1'b0, IDX_DATA, 8'h00);
        check("last byte", rdv, SLV_BYTE);
    endtask

    task automatic t_nack();
        apb(1'b1, IDX_DATA, 8'h22);
        apb(1'b1, IDX_CMD_STAT, 8'hD1);
        wait_st(8'h42, 8'h00);
        check("no ack", rdv, 8'h81);
        apb(1'b1, IDX_CMD_STAT, 8'h01);
    endtask

    // Another master holds SDA low from before the start until arbitration is lost
    task automatic t_arb();
        apb(1'b1, IDX_DATA, {SLV_ADDR, 1'b0});
        apb(1'b1, IDX_CMD_STAT, 8'h90);
        tb_pull <= 1'b1;
        wait_st(8'h02, 8'h00);
        check("arb lost", rdv & 8'h21, 8'h21);
        tb_pull <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, IDX_CMD_STAT, 8'h00);
        check("bus freed", rdv & 8'h40, 8'h00);
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_disabled();
        t_write();
        t_read();
        t_nack();
        t_arb();
        results();
    end
endmodule
